//--- adcsx_cfg.svh
// Register offsets, field positions, reset values and timing for adcsx
`ifndef ADCSX_CFG_SVH
`define ADCSX_CFG_SVH
`define ADCSX_OFS_SYNC_CTRL   8'h1A
`define ADCSX_OFS_EXT_MUX     8'hD0
`define ADCSX_OFS_MUX_ENABLE  8'hD6
`define ADCSX_OFS_CHAN_SYNC   8'h20
`define ADCSX_OFS_CHAN_INCLS  8'h22
`define ADCSX_OFS_GLOB_CTRL   8'h24
`define ADCSX_OFS_STATUS      8'h26
`define ADCSX_OFS_REQUEST     8'h28
`define ADCSX_OFS_ALIAS       8'h2A
`define ADCSX_EXT_SELECT_OUTPUTS_SET_LSB    0
`define ADCSX_EXT_SELECT_OUTPUTS_LAST_LSB   4
`define ADCSX_EXT_SELECT_OUTPUTS_SAMP_LSB   8
`define ADCSX_SYNC_STATE_SOURCE_SELECT_LSB  0
`define ADCSX_SYNC_EVAL_BIT   4
`define ADCSX_RST_VALUE       16'h0000
`define ADCSX_ALT_SAMPLE_BASE 10'h002
`define ADCSX_CONV_BITS_8     4'h8
`endif

//--- adcsx_pkg.sv
// Types shared by the adcsx converter control files
package adcsx_pkg;
  typedef enum logic [2:0] {
    ADCSX_IDLE   = 3'b000,
    ADCSX_WAIT   = 3'b001,
    ADCSX_SAMPLE = 3'b010,
    ADCSX_CONV   = 3'b011,
    ADCSX_DONE   = 3'b100
  } adcsx_state_t;

  typedef struct packed {
    logic       req;
    logic [3:0] chan;
    logic [1:0] analog_power_state;
  } adcsx_link_t;

  typedef struct packed {
    logic [2:0] setMux;
    logic [2:0] lastMux;
    logic [7:0] sampleExt;
  } adcsx_mux_t;
endpackage

//--- adcsx_phase_timer.sv
// Down counter that times sample and conversion phases
`timescale 1ns/1ps
module adcsx_phase_timer #(
  parameter int WIDTH = 10
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadValue,
  output logic                  expired
);
  logic [WIDTH-1:0] count_q;

  initial begin
    if (WIDTH < 2) begin
      $error("adcsx_phase_timer: WIDTH too small");
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= loadValue;
    end else if (count_q != '0) begin
      count_q <= count_q - WIDTH'(1);
    end
  end

  // Not gated by load: the sequencer reloads on expiry, a gate would loop
  assign expired = count_q == WIDTH'(1);
endmodule

//--- adcsx_sync_ctrl.sv
// Conversion-group synchronisation and external multiplexer control
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Master forwards request and channel when flagged
// - Slave never originates synchronisation requests
// - Slave converts own requests when idle
// - Both kernels start sample phase together
// - Each kernel keeps own resolution, sample length
// - Master alone sets channel
// - Started parallel conversion is never aborted
// - Slave serves parallel request first when idle; a running local conversion is cancelled and repeated, request dropped
// - Master waits for read; slave overwrites
// - Master distributes analog power state
// - Master presents requested channel alongside state
// - Ready evaluation holds start for partner
// - Own alias redirection applied per kernel
// - Bits 2:0 hold next mux setting
// - Bits 6:4 show applied mux setting
// - Changed setting uses extension sample phase
// - Alternative phase is two plus extension
// - Reserved bits 3 and 7 read zero
// - Copy next to applied at conversion start
// - Disabled channel leaves outputs, uses class
// - Repeat after abort keeps alternative phase
`include "adcsx_cfg.svh"
module adcsx_sync_ctrl #(
  parameter int CHANNELS = 8
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [7:0]             regAddr,
  input  wire logic [15:0]            regWrData,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output logic [15:0]                 regRdData,
  input  wire logic                   localReq,
  input  wire logic [3:0]             localChan,
  input  wire logic                   localPrioReq,
  input  wire adcsx_pkg::adcsx_link_t syncIn,
  output adcsx_pkg::adcsx_link_t      syncOut,
  input  wire logic                   partnerReady,
  output logic                        readyOut,
  input  wire logic [1:0]             localAnon,
  input  wire logic                   resultRead,
  output logic [2:0]                  extSelect,
  output logic                        convActive,
  output logic                        sampleActive,
  output logic [3:0]                  convChan,
  output logic                        convParallel,
  output logic                        resultValid
);
  import adcsx_pkg::*;

  // ***************************************************
  // Elaboration check
  // ***************************************************
  initial begin
    if (CHANNELS < 1 || CHANNELS > 8) begin
      $error("adcsx_sync_ctrl: CHANNELS must be 1 to 8");
    end
  end

  // ***************************************************
  // Registers
  // ***************************************************
  logic [1:0]   state_source_select_q;
  logic         evalReady_q;
  logic [7:0]   muxEnable_q;
  logic [7:0]   chanSync_q;
  logic [7:0]   inClass_q;
  logic [3:0]   resBits_q;
  logic         waitRead_q;
  logic         isSlave_q;
  logic [3:0]   channel_redirect_zero_q;
  logic [2:0]   setMux_q, lastMux_q;
  logic [7:0]   sampleExt_q;
  adcsx_mux_t   mux_q;
  logic         altPending_q;
  logic [15:0]  rdData_q;
  adcsx_state_t state_q;
  logic [3:0]   chan_q;
  logic         par_q;
  logic         alt_q;
  logic         resultValid_q;
  logic         pendLocal_q;
  logic [3:0]   pendChan_q;

  function automatic logic [15:0] readMux(input adcsx_mux_t m);
    readMux = {m.sampleExt, 1'b0, m.lastMux, 1'b0, m.setMux};
  endfunction

  function automatic logic [3:0] redirect(input logic [3:0] c,
                                          input logic [3:0] a);
    redirect = (c == 4'h0) ? a : c;
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_source_select_q     <= 2'h0;
      evalReady_q <= 1'b0;
      muxEnable_q <= 8'h00;
      chanSync_q  <= 8'h00;
      inClass_q   <= 8'h00;
      resBits_q   <= 4'h0;
      waitRead_q  <= 1'b0;
      isSlave_q   <= 1'b0;
      channel_redirect_zero_q    <= 4'h0;
      setMux_q    <= 3'h0;
      sampleExt_q <= 8'h00;
    end else if (regWrite) begin
      case (regAddr)
        `ADCSX_OFS_SYNC_CTRL: begin
          state_source_select_q     <= regWrData[`ADCSX_SYNC_STATE_SOURCE_SELECT_LSB +: 2];
          evalReady_q <= regWrData[`ADCSX_SYNC_EVAL_BIT];
        end
        `ADCSX_OFS_EXT_MUX: begin
          setMux_q    <= regWrData[`ADCSX_EXT_SELECT_OUTPUTS_SET_LSB +: 3];
          sampleExt_q <= regWrData[`ADCSX_EXT_SELECT_OUTPUTS_SAMP_LSB +: 8];
        end
        `ADCSX_OFS_MUX_ENABLE: begin
          for (int i = 0; i < 8; i++) begin
            muxEnable_q[i] <= regWrData[2*i];
          end
        end
        `ADCSX_OFS_CHAN_SYNC: chanSync_q <= regWrData[7:0];
        `ADCSX_OFS_CHAN_INCLS: inClass_q <= regWrData[7:0];
        `ADCSX_OFS_GLOB_CTRL: begin
          resBits_q  <= regWrData[3:0];
          waitRead_q <= regWrData[4];
          isSlave_q  <= regWrData[5];
        end
        `ADCSX_OFS_ALIAS: channel_redirect_zero_q <= regWrData[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_q <= `ADCSX_RST_VALUE;
    end else if (regRead) begin
      case (regAddr)
        `ADCSX_OFS_SYNC_CTRL:
          rdData_q <= {11'h000, evalReady_q, 2'h0, state_source_select_q};
        `ADCSX_OFS_EXT_MUX: rdData_q <= readMux(mux_q);
        `ADCSX_OFS_MUX_ENABLE: begin
          rdData_q <= 16'h0000;
          for (int i = 0; i < 8; i++) begin
            rdData_q[2*i] <= muxEnable_q[i];
          end
        end
        `ADCSX_OFS_CHAN_SYNC:  rdData_q <= {8'h00, chanSync_q};
        `ADCSX_OFS_CHAN_INCLS: rdData_q <= {8'h00, inClass_q};
        `ADCSX_OFS_GLOB_CTRL:
          rdData_q <= {10'h000, isSlave_q, waitRead_q, resBits_q};
        `ADCSX_OFS_STATUS:
          rdData_q <= {8'h00, resultValid_q, par_q, alt_q,
                       2'(state_q), chan_q[2:0]};
        `ADCSX_OFS_ALIAS: rdData_q <= {12'h000, channel_redirect_zero_q};
        default: rdData_q <= 16'h0000;
      endcase
    end else begin
      rdData_q <= 16'h0000;
    end
  end
  assign regRdData = rdData_q;

  // ***************************************************
  // Request selection
  // ***************************************************
  logic        incoming;
  logic        startReq;
  logic [3:0]  startChan;
  logic        startPar;
  logic        resultBlocked;
  logic        timerLoad;
  logic [9:0]  timerValue;
  logic        timerDone;
  logic        localFlagged;

  // Slave listens only when its source select points at the master
  assign incoming = isSlave_q && (state_source_select_q == 2'h1) && syncIn.req;
  assign localFlagged = localReq && chanSync_q[localChan[2:0]];
  // Any unread result, parallel or not, blocks new local starts in the master only
  assign resultBlocked = waitRead_q && !isSlave_q && resultValid_q;

  always_comb begin
    startReq  = 1'b0;
    startChan = 4'h0;
    startPar  = 1'b0;
    if (incoming) begin
      startReq  = 1'b1;
      startChan = syncIn.chan;
      startPar  = 1'b1;
    end else if (pendLocal_q) begin
      startReq  = 1'b1;
      startChan = pendChan_q;
    end else if (localReq && !resultBlocked) begin
      startReq  = 1'b1;
      startChan = localChan;
      startPar  = localFlagged && !isSlave_q;
    end
  end

  // ***************************************************
  // Conversion sequencer
  // ***************************************************
  logic muxUse;
  logic muxChanged;
  logic idleStart;
  logic abortNow;
  assign idleStart  = (state_q == ADCSX_IDLE) && startReq;
  assign muxUse     = muxEnable_q[startChan[2:0]];
  assign muxChanged = mux_q.setMux != mux_q.lastMux;
  // Only non-parallel conversions may be cancelled
  assign abortNow   = !par_q && (state_q == ADCSX_SAMPLE ||
                      state_q == ADCSX_CONV) && (incoming || localPrioReq);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q     <= ADCSX_IDLE;
      chan_q      <= 4'h0;
      par_q       <= 1'b0;
      pendLocal_q <= 1'b0;
      pendChan_q  <= 4'h0;
    end else begin
      case (state_q)
        ADCSX_IDLE: begin
          if (startReq) begin
            chan_q <= redirect(startChan, channel_redirect_zero_q);
            par_q  <= startPar;
            if (!incoming) begin
              pendLocal_q <= 1'b0;
            end
            state_q <= (startPar && evalReady_q) ? ADCSX_WAIT
                                                : ADCSX_SAMPLE;
          end
        end
        ADCSX_WAIT: begin
          if (partnerReady) begin
            state_q <= ADCSX_SAMPLE;
          end
        end
        ADCSX_SAMPLE: begin
          if (abortNow) begin
            pendLocal_q <= 1'b1;
            pendChan_q  <= chan_q;
            state_q     <= ADCSX_IDLE;
          end else if (timerDone) begin
            state_q <= ADCSX_CONV;
          end
        end
        ADCSX_CONV: begin
          if (abortNow) begin
            pendLocal_q <= 1'b1;
            pendChan_q  <= chan_q;
            state_q     <= ADCSX_IDLE;
          end else if (timerDone) begin
            state_q <= ADCSX_DONE;
          end
        end
        ADCSX_DONE: state_q <= ADCSX_IDLE;
        default: state_q <= ADCSX_IDLE;
      endcase
    end
  end

  // ***************************************************
  // External multiplexer
  // ***************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastMux_q     <= 3'h0;
      altPending_q  <= 1'b0;
      alt_q         <= 1'b0;
    end else begin
      if (idleStart && muxUse) begin
        lastMux_q <= setMux_q;
        // A repeat keeps the alternative phase until it completes
        alt_q <= muxChanged || altPending_q;
        altPending_q <= muxChanged || altPending_q;
      end else if (idleStart) begin
        alt_q <= 1'b0;
      end
      if (state_q == ADCSX_DONE && alt_q) begin
        altPending_q <= 1'b0;
      end
    end
  end
  assign mux_q     = {setMux_q, lastMux_q, sampleExt_q};
  assign extSelect = lastMux_q;

  // ***************************************************
  // Phase timing
  // ***************************************************
  logic enterSample;
  assign enterSample = (state_q == ADCSX_WAIT && partnerReady) ||
                       (idleStart && !(startPar && evalReady_q));

  always_comb begin
    timerLoad  = 1'b0;
    timerValue = 10'h000;
    if (enterSample) begin
      timerLoad = 1'b1;
      if (idleStart) begin
        timerValue = (muxUse && (muxChanged || altPending_q)) ?
          `ADCSX_ALT_SAMPLE_BASE + {2'h0, mux_q.sampleExt} :
          `ADCSX_ALT_SAMPLE_BASE + {9'h000, inClass_q[startChan[2:0]]};
      end else begin
        timerValue = alt_q ?
          `ADCSX_ALT_SAMPLE_BASE + {2'h0, mux_q.sampleExt} :
          `ADCSX_ALT_SAMPLE_BASE + {9'h000, inClass_q[chan_q[2:0]]};
      end
    end else if (state_q == ADCSX_SAMPLE && timerDone) begin
      timerLoad  = 1'b1;
      timerValue = {6'h00, resBits_q} + 10'h002;
    end
  end

  adcsx_phase_timer #(
    .WIDTH(10)
  ) u_timer (
    .clk       (clk),
    .rst       (rst),
    .load      (timerLoad),
    .loadValue (timerValue),
    .expired   (timerDone)
  );

  // ***************************************************
  // Results and link outputs
  // ***************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resultValid_q <= 1'b0;
    end else if (state_q == ADCSX_DONE) begin
      resultValid_q <= 1'b1;
    end else if (resultRead) begin
      resultValid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncOut <= '0;
    end else begin
      syncOut.req  <= !isSlave_q && idleStart && startPar;
      syncOut.chan <= startChan;
      syncOut.analog_power_state <= isSlave_q ? 2'h0 : localAnon;
    end
  end

  assign readyOut     = (state_q == ADCSX_WAIT) ||
                        (state_q == ADCSX_IDLE && incoming);
  assign convActive   = state_q != ADCSX_IDLE;
  assign sampleActive = state_q == ADCSX_SAMPLE;
  assign convChan     = chan_q;
  assign convParallel = par_q;
  assign resultValid  = resultValid_q;
endmodule

//--- adcsx_sync_ctrl_sva.sv
// Assertion checker for the adcsx synchronisation and mux control
`timescale 1ns/1ps
module adcsx_sync_ctrl_sva (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic [7:0]             regAddr,
  input wire logic [15:0]            regWrData,
  input wire logic                   regWrite,
  input wire logic                   regRead,
  input wire logic [15:0]            regRdData,
  input wire logic [3:0]             localChan,
  input wire logic                   localPrioReq,
  input wire adcsx_pkg::adcsx_link_t syncOut,
  input wire logic                   partnerReady,
  input wire logic [1:0]             localAnon,
  input wire logic [2:0]             extSelect,
  input wire logic                   convActive,
  input wire logic                   sampleActive,
  input wire logic                   convParallel
);
  import adcsx_pkg::*;
  // ****
  // Role shadows, rebuilt from register writes
  // ****
  logic slaveQ;
  logic evalQ;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) slaveQ <= 1'b0;
    else if (regWrite && regAddr == 8'h24) slaveQ <= regWrData[5];
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) evalQ <= 1'b0;
    else if (regWrite && regAddr == 8'h1A) evalQ <= regWrData[4];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_rsv_zero: assert property (
    $past(regRead) && $past(regAddr) == 8'hD0
    |-> regRdData[7] == 1'b0 && regRdData[3] == 1'b0)
    else $error("reserved mux bits read nonzero");
  chk_last_field: assert property (
    $past(regRead) && $past(regAddr) == 8'hD0
    |-> regRdData[6:4] == $past(extSelect))
    else $error("applied mux field differs from select outputs");
  chk_slave_quiet: assert property (
    slaveQ |-> !syncOut.req)
    else $error("slave issued a group request");
  chk_sync_pulse: assert property (
    syncOut.req |=> !syncOut.req)
    else $error("group request longer than one cycle");
  chk_sync_start: assert property (
    $rose(convActive) && convParallel && !slaveQ |-> ##[0:1] syncOut.req)
    else $error("parallel start without group request");
  chk_sync_chan: assert property (
    syncOut.req |-> syncOut.chan == $past(localChan))
    else $error("group request carries wrong channel");
  chk_analog_power_state_fwd: assert property (
    syncOut.req |-> syncOut.analog_power_state == $past(localAnon))
    else $error("group request carries wrong power state");
  chk_par_hold: assert property (
    convParallel && sampleActive && localPrioReq |=> convActive)
    else $error("parallel conversion aborted");
  chk_ready_wait: assert property (
    evalQ && convParallel && $rose(sampleActive) |-> $past(partnerReady))
    else $error("parallel sample began without partner ready");
  chk_mux_sel: assert property (
    !$stable(extSelect) |-> $rose(convActive))
    else $error("select outputs moved outside a conversion start");
endmodule
bind adcsx_sync_ctrl adcsx_sync_ctrl_sva adcsx_sync_ctrl_sva_i (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .localChan(localChan), .localPrioReq(localPrioReq), .syncOut(syncOut),
  .partnerReady(partnerReady), .localAnon(localAnon),
  .extSelect(extSelect), .convActive(convActive),
  .sampleActive(sampleActive), .convParallel(convParallel));

//--- adcsx_partner_model.sv
// Model of the other kernel of the conversion group
`timescale 1ns/1ps
module adcsx_partner_model (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              fire,
  input  wire logic [3:0]        fireChan,
  input  wire logic              hold,
  input  wire logic [3:0]        lag,
  output adcsx_pkg::adcsx_link_t link,
  output logic                   ready
);
  import adcsx_pkg::*;
  logic [3:0] waitQ;
  logic [3:0] lastChanQ;
  // ****
  // Master side: one-cycle request, channel junk between requests
  // ****
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link      <= '0;
      lastChanQ <= 4'h0;
    end else if (fire) begin
      link      <= '{req: 1'b1, chan: fireChan, analog_power_state: 2'h3};
      lastChanQ <= fireChan;
    end else begin
      link      <= '{req: 1'b0, chan: ~lastChanQ, analog_power_state: 2'h3};
    end
  end
  // Slow partner: ready only after lag cycles of hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) waitQ <= 4'h0;
    else if (!hold) waitQ <= 4'h0;
    else if (waitQ != lag) waitQ <= waitQ + 4'h1;
  end
  assign ready = hold && waitQ == lag;
endmodule

//--- tb_top.sv
// Self-checking bench for adcsx_sync_ctrl
`timescale 1ns/1ps
module tb_top;
  import adcsx_pkg::*;
  logic        clk, rst, regWrite, regRead, localReq, localPrioReq;
  logic        resultRead, fire, hold, readyOut, convActive, sampleActive;
  logic        convParallel, resultValid, partnerReady, rdSeen;
  logic [7:0]  regAddr, extV;
  logic [15:0] regWrData, regRdData;
  logic [3:0]  localChan, convChan, fireChan, lag;
  logic [1:0]  localAnon;
  logic [2:0]  extSelect, setV;
  adcsx_link_t syncIn, syncOut;
  logic [15:0] rdQ[$];
  int          error_cnt, total_checks, sampLen, sampCnt, reqCnt, rdyCnt;
  adcsx_sync_ctrl adcsx_sync_ctrl_i (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .localReq(localReq),
    .localChan(localChan), .localPrioReq(localPrioReq), .syncIn(syncIn),
    .syncOut(syncOut), .partnerReady(partnerReady), .readyOut(readyOut),
    .localAnon(localAnon), .resultRead(resultRead),
    .extSelect(extSelect), .convActive(convActive),
    .sampleActive(sampleActive), .convChan(convChan),
    .convParallel(convParallel), .resultValid(resultValid));
  adcsx_partner_model adcsx_partner_model_i (.clk(clk), .rst(rst),
    .fire(fire), .fireChan(fireChan), .hold(hold), .lag(lag),
    .link(syncIn), .ready(partnerReady));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ****
  // Checking, read monitor and phase counters
  // ****
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) rdSeen <= regRead;
  always @(negedge clk) begin
    if (rdSeen && rdQ.size() > 0)
      check("regRdData", regRdData, rdQ.pop_front());
  end
  // Sample length is counted in whole cycles of sampleActive
  always @(posedge clk) begin
    if (syncOut.req === 1'b1) reqCnt <= reqCnt + 1;
    if (readyOut === 1'b1) rdyCnt <= rdyCnt + 1;
    if (sampleActive === 1'b1) sampCnt <= sampCnt + 1;
    else if (sampCnt != 0) begin
      sampLen <= sampCnt;
      sampCnt <= 0;
    end
  end
  // ****
  // Bus and conversion tasks; a gap cycle keeps strobes single-driven
  // ****
  task automatic wr(logic [7:0] a, logic [15:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge clk);
    regWrite  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] exp);
    regAddr <= a;
    regRead <= 1'b1;
    rdQ.push_back(exp);
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_done();
    for (int n = 0; n < 300 && resultValid !== 1'b1; n++) @(negedge clk);
    check("resultValid", 16'(resultValid), 16'h0001);
    @(posedge clk);
    resultRead <= 1'b1;
    @(posedge clk);
    resultRead <= 1'b0;
  endtask
  task automatic conv(logic [3:0] ch, logic prio);
    localChan <= ch;
    localReq  <= 1'b1;
    @(posedge clk);
    localReq  <= 1'b0;
    if (prio) begin
      for (int n = 0; n < 50 && sampleActive !== 1'b1; n++) @(negedge clk);
      check("sampleActive", 16'(sampleActive), 16'h0001);
      @(posedge clk);
      localPrioReq <= 1'b1;
      @(posedge clk);
      localPrioReq <= 1'b0;
    end
    wait_done();
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    {regWrite, regRead, localReq, localPrioReq, resultRead} = '0;
    {fire, hold, regAddr, regWrData, localChan, fireChan, lag} = '0;
    localAnon = 2'h3;
    rst = 1'b1;
    void'($urandom(54));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'hD0, 16'h0000);
    rd(8'hFE, 16'h0000);
    setV = 3'($urandom_range(1, 7));
    extV = 8'($urandom_range(0, 6));
    wr(8'hD0, {extV, 1'b1, 3'h7, 1'b1, setV});
    rd(8'hD0, {extV, 5'h00, setV});
    wr(8'hD6, 16'h0010);
    conv(4'h2, 1'b0);
    check("extSelect", 16'(extSelect), 16'(setV));
    check("sampLen", 16'(sampLen), 16'(extV) + 16'h0002);
    rd(8'hD0, {extV, 1'b0, setV, 1'b0, setV});
    wr(8'hD0, {extV, 5'h00, ~setV});
    conv(4'h1, 1'b0);
    check("extSelect", 16'(extSelect), 16'(setV));
    // Changed setting, first conversion aborted: repeat keeps long phase
    conv(4'h2, 1'b1);
    check("extSelect", 16'(extSelect), {13'h0000, ~setV});
    check("sampLen", 16'(sampLen), 16'(extV) + 16'h0002);
    // Master of the group; partner software setup matches
    wr(8'h24, 16'h0000);
    wr(8'h1A, 16'h0010);
    wr(8'h20, 16'h0008);
    hold <= 1'b1;
    lag  <= 4'h6;
    localAnon <= 2'($urandom_range(0, 3));
    conv(4'h3, 1'b1);
    check("convChan", 16'(convChan), 16'h0003);
    check("reqCnt", 16'(reqCnt), 16'h0001);
    check("readyOut", 16'(rdyCnt), 16'(lag));
    hold <= 1'b0;
    // Slave of the group
    wr(8'h24, 16'h0020);
    wr(8'h1A, 16'h0011);
    hold     <= 1'b1;
    lag      <= 4'h0;
    fireChan <= 4'h5;
    fire     <= 1'b1;
    @(posedge clk);
    fire     <= 1'b0;
    wait_done();
    check("convChan", 16'(convChan), 16'h0005);
    check("convParallel", 16'(convParallel), 16'h0001);
    check("readyOut", 16'(rdyCnt), 16'h0008);
    conv(4'h2, 1'b0);
    check("convChan", 16'(convChan), 16'h0002);
    check("convParallel", 16'(convParallel), 16'h0000);
    check("reqCnt", 16'(reqCnt), 16'h0001);
    wrap_up();
  end
endmodule
